// *** core/dcc_top.sv ***
/*
  Dual down-counter control: mode byte, two 16-bit counters that can be
  joined into one 32-bit counter, count-output pin source and waveform,
  sticky zero-detect interrupts, and a simple register port.
  Assumes a one-cycle strobe register master on core_clk and an external
  count clock arriving asynchronously on a pin.
*/
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dcc_top #(
  parameter int OSC_HALF = dcc_pkg::OSC_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [dcc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [dcc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [dcc_pkg::DATA_W-1:0]  reg_rdata,
  // Pins
  input  wire logic                        ext_count_clk,
  output logic                             count_output_pin,
  output logic                             count_output_pin_oe_n,
  // Interrupt
  output logic                             irq
);
  localparam int CW = dcc_pkg::CNT_W;
  localparam int OW = (OSC_HALF > 1) ? $clog2(OSC_HALF) : 1;

  dcc_cnt_if #(.W(CW)) lo_if ();
  dcc_cnt_if #(.W(CW)) hi_if ();

  // No reset clause: the mode byte survives reset, so it only has a
  // power-up value
  logic [dcc_pkg::MODE_W-1:0] counter_mode_control = '0;
  logic [CW-1:0]              low_reload;
  logic [CW-1:0]              high_reload;
  logic [dcc_pkg::IRQ_W-1:0]  irq_status;
  logic [dcc_pkg::IRQ_W-1:0]  irq_mask;
  logic                       pin_waveform_select;
  logic                       high_single_step;
  logic                       low_single_step;
  logic                       tick;
  logic [OW-1:0]              osc_cnt;
  logic                       osc_tick;
  logic                       wr_mode;
  logic                       counter_join_select;
  logic                       prescale_bypass;
  logic                       high_run;
  logic                       low_run;
  logic                       high_dec;
  logic                       low_dec;
  logic                       low_evt;
  logic                       high_evt;
  logic                       sel_evt;
  logic [dcc_pkg::IRQ_W-1:0]  irq_set;
  logic [dcc_pkg::IRQ_W-1:0]  irq_clr;
  dcc_pkg::dcc_pin_src_type   pin_src;

  // Field views of the mode byte
  assign counter_join_select = counter_mode_control[dcc_pkg::BIT_JOIN];
  assign prescale_bypass     = counter_mode_control[dcc_pkg::BIT_BYPASS];
  assign high_run            = counter_mode_control[dcc_pkg::BIT_RUN_H];
  assign low_run             = counter_mode_control[dcc_pkg::BIT_RUN_L];
  assign pin_src             = dcc_pkg::dcc_pin_src_type'(
                                 counter_mode_control[dcc_pkg::BIT_SEL_HI:dcc_pkg::BIT_SEL_LO]);
  assign wr_mode             = reg_wr && (reg_addr == dcc_pkg::ADDR_MODE);

  // no reset; step bits stored as zero
  always_ff @(posedge core_clk) begin
    if (wr_mode) begin
      counter_mode_control <= {reg_wdata[dcc_pkg::MODE_W-1:dcc_pkg::BIT_RUN_L], 2'b00};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      high_single_step <= 1'b0;
      low_single_step  <= 1'b0;
    end else begin
      high_single_step <= wr_mode && reg_wdata[dcc_pkg::BIT_STEP_H];
      low_single_step  <= wr_mode && reg_wdata[dcc_pkg::BIT_STEP_L];
    end
  end

  // Reload values, pin and interrupt configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_reload          <= '0;
      high_reload         <= '0;
      irq_mask            <= '0;
      pin_waveform_select <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == dcc_pkg::ADDR_LOW_RELOAD) begin
        low_reload <= reg_wdata[CW-1:0];
      end
      if (reg_addr == dcc_pkg::ADDR_HIGH_RELOAD) begin
        high_reload <= reg_wdata[CW-1:0];
      end
      if (reg_addr == dcc_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= reg_wdata[dcc_pkg::IRQ_W-1:0];
      end
      if (reg_addr == dcc_pkg::ADDR_PIN_CFG) begin
        pin_waveform_select <= reg_wdata[dcc_pkg::BIT_WAVE];
      end
    end
  end

  // External count clock front end
  dcc_prescale #(.DIV(dcc_pkg::PRESCALE_DIV)) u_prescale (
    .core_clk      (core_clk),
    .rst           (rst),
    .ext_count_clk (ext_count_clk),
    .bypass        (prescale_bypass),
    .tick          (tick)
  );

  // high base strobe: tick when running, step only when halted
  assign high_dec = high_run ? tick : high_single_step;
  // low base strobe, dead while joined
  assign low_dec  = !counter_join_select && (low_run ? tick : low_single_step);

  // joined mode: low half borrows into the high half
  assign lo_if.dec    = counter_join_select ? high_dec : low_dec;
  assign hi_if.dec    = counter_join_select ? (high_dec && (lo_if.value == '0)) : high_dec;
  assign lo_if.reload = low_reload;
  assign hi_if.reload = high_reload;

  dcc_down_counter #(.W(CW)) u_low (
    .core_clk (core_clk),
    .rst      (rst),
    .cnt      (lo_if.cnt)
  );

  dcc_down_counter #(.W(CW)) u_high (
    .core_clk (core_clk),
    .rst      (rst),
    .cnt      (hi_if.cnt)
  );

  // joined zero means the low half lands while the high half is zero
  assign low_evt  = !counter_join_select && lo_if.reached_zero;
  assign high_evt = counter_join_select ? (lo_if.reached_zero && (hi_if.value == '0))
                                        : hi_if.reached_zero;

  // Sampling oscillator, a free one-cycle tick every OSC_HALF core clocks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_tick ? '0 : osc_cnt + OW'(1);
    end
  end

  assign osc_tick = (osc_cnt == OW'(OSC_HALF - 1));

  always_comb begin
    unique case (pin_src)
      dcc_pkg::SRC_OSC:    sel_evt = osc_tick;
      dcc_pkg::SRC_LOW:    sel_evt = lo_if.reached_zero;
      dcc_pkg::SRC_HIGH:   sel_evt = hi_if.reached_zero;
      dcc_pkg::SRC_JOINED: sel_evt = counter_join_select ? high_evt
                                     : (lo_if.reached_zero || hi_if.reached_zero);
    endcase
  end

  // square wave toggles, pulsed form follows the event
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_output_pin <= 1'b0;
    end else if (pin_waveform_select) begin
      count_output_pin <= sel_evt;
    end else if (sel_evt) begin
      count_output_pin <= !count_output_pin;
    end
  end

  // Pin direction lives elsewhere; this block always drives
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_output_pin_oe_n <= 1'b0;
    end else begin
      count_output_pin_oe_n <= 1'b0;
    end
  end

  // joined events only reach the high interrupt bit
  assign irq_set = {high_evt, low_evt};
  assign irq_clr = (reg_wr && (reg_addr == dcc_pkg::ADDR_IRQ_STATUS))
                   ? reg_wdata[dcc_pkg::IRQ_W-1:0] : '0;

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data for exactly one cycle; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        dcc_pkg::ADDR_MODE:        reg_rdata <= dcc_pkg::DATA_W'(counter_mode_control);
        dcc_pkg::ADDR_LOW_RELOAD:  reg_rdata <= dcc_pkg::DATA_W'(low_reload);
        dcc_pkg::ADDR_HIGH_RELOAD: reg_rdata <= dcc_pkg::DATA_W'(high_reload);
        dcc_pkg::ADDR_LOW_VALUE:   reg_rdata <= dcc_pkg::DATA_W'(lo_if.value);
        dcc_pkg::ADDR_HIGH_VALUE:  reg_rdata <= dcc_pkg::DATA_W'(hi_if.value);
        dcc_pkg::ADDR_IRQ_STATUS:  reg_rdata <= dcc_pkg::DATA_W'(irq_status);
        dcc_pkg::ADDR_IRQ_MASK:    reg_rdata <= dcc_pkg::DATA_W'(irq_mask);
        dcc_pkg::ADDR_PIN_CFG:     reg_rdata <= dcc_pkg::DATA_W'(pin_waveform_select);
        default:                   reg_rdata <= '0;
      endcase
    end
  end

  // Helper: mode byte as last seen outside reset
  logic [dcc_pkg::MODE_W-1:0] mode_before_rst;
  logic                       wrote_in_rst;
  always_ff @(posedge core_clk) begin
    if (!rst) begin
      mode_before_rst <= counter_mode_control;
      // A write on the last edge before reset already moved the byte
      wrote_in_rst    <= wr_mode;
    end else if (wr_mode) begin
      wrote_in_rst    <= 1'b1;
    end
  end

  property p_mode_kept;
    @(posedge core_clk) disable iff (rst)
      ($fell(rst) && !wrote_in_rst) |-> (counter_mode_control == mode_before_rst);
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("mode byte changed by reset");

  property p_step_reads_zero;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && (reg_addr == dcc_pkg::ADDR_MODE))
        |=> (reg_rdata[dcc_pkg::BIT_STEP_H:dcc_pkg::BIT_STEP_L] == 2'b00);
  endproperty
  a_step_reads_zero: assert property (p_step_reads_zero) else $error("step bits read nonzero");

  property p_step_high;
    @(posedge core_clk) disable iff (rst)
      (wr_mode && reg_wdata[dcc_pkg::BIT_STEP_H] && !reg_wdata[dcc_pkg::BIT_RUN_H]
       && !reg_wdata[dcc_pkg::BIT_JOIN])
        |=> ##1 ((hi_if.value != $past(hi_if.value)) || ($past(hi_if.value) == '0));
  endproperty
  a_step_high: assert property (p_step_high) else $error("high step did not decrement");

  property p_step_low_joined;
    @(posedge core_clk) disable iff (rst)
      (wr_mode && reg_wdata[dcc_pkg::BIT_STEP_L] && reg_wdata[dcc_pkg::BIT_JOIN]
       && !reg_wdata[dcc_pkg::BIT_STEP_H] && !reg_wdata[dcc_pkg::BIT_RUN_H])
        |=> ##1 $stable(lo_if.value);
  endproperty
  a_step_low_joined: assert property (p_step_low_joined) else $error("low step acted while joined");

  property p_halt_high;
    @(posedge core_clk) disable iff (rst)
      (!counter_join_select && !high_run && !high_single_step) |=> $stable(hi_if.value);
  endproperty
  a_halt_high: assert property (p_halt_high) else $error("halted high counter moved");

  property p_joined_halt;
    @(posedge core_clk) disable iff (rst)
      (counter_join_select && !high_run && !high_single_step) |=> $stable(lo_if.value);
  endproperty
  a_joined_halt: assert property (p_joined_halt) else $error("joined counter moved under low bits");

  property p_run_low;
    @(posedge core_clk) disable iff (rst)
      (!counter_join_select && low_run && tick && (lo_if.value != '0))
        |=> (lo_if.value == $past(lo_if.value) - CW'(1));
  endproperty
  a_run_low: assert property (p_run_low) else $error("running low counter missed a tick");

  property p_select_low;
    @(posedge core_clk) disable iff (rst)
      ((pin_src == dcc_pkg::SRC_LOW) && pin_waveform_select && lo_if.reached_zero) |=> count_output_pin;
  endproperty
  a_select_low: assert property (p_select_low) else $error("low zero missing on pin");

  property p_either_zero;
    @(posedge core_clk) disable iff (rst)
      ((pin_src == dcc_pkg::SRC_JOINED) && !counter_join_select && pin_waveform_select
       && hi_if.reached_zero) |=> count_output_pin;
  endproperty
  a_either_zero: assert property (p_either_zero) else $error("high zero missing on pin");

  property p_square;
    @(posedge core_clk) disable iff (rst)
      (!pin_waveform_select && sel_evt) |=> (count_output_pin != $past(count_output_pin));
  endproperty
  a_square: assert property (p_square) else $error("square wave did not toggle");

  property p_joined_no_low_irq;
    @(posedge core_clk) disable iff (rst)
      (counter_join_select && !irq_status[dcc_pkg::IRQ_LOW]) |=> !irq_status[dcc_pkg::IRQ_LOW];
  endproperty
  a_joined_no_low_irq: assert property (p_joined_no_low_irq) else $error("low irq set while joined");

endmodule : dcc_top

`default_nettype wire

// *** core/dcc_pkg.sv ***
/*
  Shared constants for the dual down-counter control block: register
  offsets, mode-byte layout, interrupt bits and timing figures.
  Assumes a single 25 MHz core clock and a word-addressed register port.
*/
package dcc_pkg;

  // Register port shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int MODE_W = 8;
  localparam int CNT_W  = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_MODE        = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LOW_RELOAD  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_RELOAD = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_LOW_VALUE   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_VALUE  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_PIN_CFG     = 4'h7;

  // Mode byte fields
  localparam int BIT_JOIN   = 7;
  localparam int BIT_BYPASS = 6;
  localparam int BIT_SEL_HI = 5;
  localparam int BIT_SEL_LO = 4;
  localparam int BIT_RUN_H  = 3;
  localparam int BIT_RUN_L  = 2;
  localparam int BIT_STEP_H = 1;
  localparam int BIT_STEP_L = 0;

  // Interrupt status and mask bits
  localparam int IRQ_W    = 2;
  localparam int IRQ_LOW  = 0;
  localparam int IRQ_HIGH = 1;

  // Pin configuration field
  localparam int BIT_WAVE = 0;

  // Timing
  localparam int PRESCALE_DIV       = 4;
  localparam int CLK_PERIOD_NS      = 40;
  localparam int OSC_HALF_PERIOD_NS = 1000;
  localparam int OSC_HALF_CYCLES    = OSC_HALF_PERIOD_NS / CLK_PERIOD_NS;

  // Count-output pin sources, in select-field order
  typedef enum logic [1:0] {
    SRC_OSC,
    SRC_LOW,
    SRC_HIGH,
    SRC_JOINED
  } dcc_pin_src_type;

endpackage : dcc_pkg

// *** core/dcc_cnt_if.sv ***
/*
  Carrier between the control logic and one 16-bit down-counter.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface dcc_cnt_if #(
  parameter int W = 16
);
  logic         dec;
  logic [W-1:0] reload;
  logic [W-1:0] value;
  logic         reached_zero;

  modport ctl (output dec, output reload, input value, input reached_zero);
  modport cnt (input dec, input reload, output value, output reached_zero);
endinterface : dcc_cnt_if

`default_nettype wire

// *** core/dcc_down_counter.sv ***
/*
  One down-counter: decrements on each dec strobe, reloads when it is
  stepped at zero, and pulses reached_zero when it lands on zero.
  Assumes dec is a one-cycle strobe from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dcc_down_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Counter carrier
  dcc_cnt_if.cnt   cnt
);

  // Value update, wrapping through the reload value
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt.value <= '0;
    end else if (cnt.dec) begin
      cnt.value <= (cnt.value == '0) ? cnt.reload : cnt.value - W'(1);
    end
  end

  // Zero-detect event, one cycle after the landing step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt.reached_zero <= 1'b0;
    end else begin
      cnt.reached_zero <= cnt.dec && (cnt.value == W'(1));
    end
  end

endmodule : dcc_down_counter

`default_nettype wire

// *** core/dcc_prescale.sv ***
/*
  External count clock front end: synchroniser, rising-edge detector and
  divide-by-four prescaler that can be bypassed.
  Assumes the external clock is slower than half the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dcc_prescale #(
  parameter int DIV = dcc_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // External clock pin and control
  input wire logic ext_count_clk,
  input wire logic bypass,
  // Effective count tick
  output logic     tick
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

  logic          sync_a;
  logic          sync_b;
  logic          prev;
  logic          rise;
  logic [DW-1:0] div;

  // Two-stage synchroniser; only sync_b reads sync_a
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= ext_count_clk;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign rise = sync_b && !prev;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= rise && (bypass || (div == DW'(DIV - 1)));
      if (rise) begin
        div <= (div == DW'(DIV - 1)) ? '0 : div + DW'(1);
      end
    end
  end

  // Edges are two cycles apart at least, so four of them span eight
  property p_prescale_gap;
    @(posedge core_clk) disable iff (rst)
      (!bypass && tick) |=> !tick [*7];
  endproperty
  a_prescale_gap: assert property (p_prescale_gap) else $error("prescaled tick too soon");

endmodule : dcc_prescale

`default_nettype wire

// *** verif/dcc_top_test.sv ***
/*
  Self-checking bench for the dual down-counter control block: register
  table, reset, single steps, prescaler, run bits, joined mode, pin, irq.
  Assumes the design package is compiled first; no partner model.
*/
`timescale 1ns/1ps
`default_nettype none

module dcc_top_test;
  typedef struct packed {
    logic [dcc_pkg::ADDR_W-1:0] addr;
    logic [15:0]                wdata;
    logic [15:0]                rexp;
  } dcc_row_type;

  // Short oscillator half period keeps the run brief
  localparam int OSC_HALF = 3;

  logic                       core_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [dcc_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [15:0]                reg_wdata = '0;
  logic                       reg_wr = 1'b0;
  logic                       reg_rd = 1'b0;
  logic [15:0]                reg_rdata;
  logic                       ext_count_clk = 1'b0;
  logic                       count_output_pin;
  logic                       count_output_pin_oe_n;
  logic                       irq;
  logic                       pin_q = 1'b0;
  logic                       lvl;
  int                         error_cnt = 0;
  int                         samples_checked = 0;
  int                         pin_rises = 0;
  int                         base;
  dcc_row_type                rows [10];

  dcc_top #(.OSC_HALF(OSC_HALF)) dut_u (
    .core_clk              (core_clk),
    .rst                   (rst),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .ext_count_clk         (ext_count_clk),
    .count_output_pin      (count_output_pin),
    .count_output_pin_oe_n (count_output_pin_oe_n),
    .irq                   (irq)
  );

  // 25 MHz core clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Pin rising-edge counter, sampled on the core clock
  always @(posedge core_clk) begin
    pin_q <= count_output_pin;
    if (count_output_pin === 1'b1 && pin_q === 1'b0) begin
      pin_rises <= pin_rises + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : rdc

  // Mode write, then time for the step strobe to land
  task automatic mode(input logic [7:0] m);
    wr(dcc_pkg::ADDR_MODE, {8'h00, m});
    idle(4);
  endtask : mode

  // Slow external clock: 8 core cycles per period, then pipeline drain
  task automatic rises(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_count_clk <= 1'b1;
      idle(4);
      ext_count_clk <= 1'b0;
      idle(3);
    end
    idle(8);
  endtask : rises

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Watchdog, well beyond the expected run of under 2000 cycles
  initial begin
    idle(6000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    rows = '{
      '{dcc_pkg::ADDR_MODE,        16'hffff, 16'h00fc},
      '{dcc_pkg::ADDR_MODE,        16'h005c, 16'h005c},
      '{dcc_pkg::ADDR_MODE,        16'h0000, 16'h0000},
      '{dcc_pkg::ADDR_LOW_RELOAD,  16'h0003, 16'h0003},
      '{dcc_pkg::ADDR_HIGH_RELOAD, 16'h0100, 16'h0100},
      '{dcc_pkg::ADDR_LOW_VALUE,   16'h1234, 16'h0000},
      '{dcc_pkg::ADDR_IRQ_STATUS,  16'h0003, 16'h0000},
      '{dcc_pkg::ADDR_IRQ_MASK,    16'h0003, 16'h0003},
      '{dcc_pkg::ADDR_PIN_CFG,     16'h0001, 16'h0001},
      '{4'hf,                      16'h5555, 16'h0000}
    };
    idle(16);
    rst <= 1'b0;
    // Mode byte survives a mid-run reset, other registers clear
    wr(dcc_pkg::ADDR_MODE, 16'h008c);
    wr(dcc_pkg::ADDR_IRQ_MASK, 16'h0003);
    @(posedge core_clk);
    rst <= 1'b1;
    idle(16);
    rst <= 1'b0;
    rdc(dcc_pkg::ADDR_MODE, 16'h008c);
    rdc(dcc_pkg::ADDR_IRQ_MASK, 16'h0000);
    check({15'h0000, count_output_pin_oe_n}, 16'h0000);
    $display("test reset done");
    // Table of write and read-back rows
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdc(rows[i].addr, rows[i].rexp);
    end
    $display("test register table done");
    // Low single steps, refused while running or joined
    mode(8'h01);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0003);
    mode(8'h05);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0003);
    mode(8'h81);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0003);
    mode(8'h11);
    base = pin_rises;
    mode(8'h11);
    mode(8'h11);
    idle(4);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0000);
    check(16'(pin_rises - base), 16'h0001);
    rdc(dcc_pkg::ADDR_IRQ_STATUS, 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    wr(dcc_pkg::ADDR_IRQ_MASK, 16'h0000);
    idle(1);
    check({15'h0000, irq}, 16'h0000);
    wr(dcc_pkg::ADDR_IRQ_MASK, 16'h0003);
    idle(1);
    check({15'h0000, irq}, 16'h0001);
    wr(dcc_pkg::ADDR_IRQ_STATUS, 16'h0001);
    idle(1);
    check({15'h0000, irq}, 16'h0000);
    rdc(dcc_pkg::ADDR_IRQ_STATUS, 16'h0000);
    // High single steps, refused while running
    mode(8'h02);
    mode(8'h0a);
    rdc(dcc_pkg::ADDR_HIGH_VALUE, 16'h0100);
    $display("test single step done");
    // Prescaled, bypassed and halted counting
    mode(8'h08);
    rises(8);
    rdc(dcc_pkg::ADDR_HIGH_VALUE, 16'h00fe);
    mode(8'h48);
    rises(5);
    rdc(dcc_pkg::ADDR_HIGH_VALUE, 16'h00f9);
    mode(8'h44);
    rises(3);
    rdc(dcc_pkg::ADDR_HIGH_VALUE, 16'h00f9);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0001);
    $display("test count clock done");
    // Joined: low run bit ignored, borrow into the high half
    mode(8'hc4);
    rises(3);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0001);
    mode(8'hc8);
    rises(2);
    rdc(dcc_pkg::ADDR_LOW_VALUE, 16'h0003);
    rdc(dcc_pkg::ADDR_HIGH_VALUE, 16'h00f8);
    $display("test joined done");
    // Either-counter source while unjoined, pulsed then square
    mode(8'h74);
    base = pin_rises;
    rises(3);
    check(16'(pin_rises - base), 16'h0001);
    wr(dcc_pkg::ADDR_PIN_CFG, 16'h0000);
    idle(3);
    lvl = count_output_pin;
    rises(4);
    check({15'h0000, count_output_pin}, {15'h0000, ~lvl});
    $display("test pin source done");
    // Reset zeroes both halves; high zero on its own source, then on either
    @(posedge core_clk);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    wr(dcc_pkg::ADDR_PIN_CFG, 16'h0001);
    wr(dcc_pkg::ADDR_LOW_RELOAD, 16'h0001);
    wr(dcc_pkg::ADDR_HIGH_RELOAD, 16'h0001);
    mode(8'h22);
    base = pin_rises;
    mode(8'h22);
    check(16'(pin_rises - base), 16'h0001);
    mode(8'h32);
    base = pin_rises;
    mode(8'h32);
    check(16'(pin_rises - base), 16'h0001);
    rdc(dcc_pkg::ADDR_IRQ_STATUS, 16'h0002);
    wr(dcc_pkg::ADDR_IRQ_STATUS, 16'h0003);
    // Joined: four steps take both halves through zero together once
    base = pin_rises;
    repeat (4) mode(8'he2);
    check(16'(pin_rises - base), 16'h0001);
    rdc(dcc_pkg::ADDR_IRQ_STATUS, 16'h0002);
    $display("test high and joined zero done");
    wrap_up();
  end
endmodule : dcc_top_test

`default_nettype wire
